// *** shared/rrsf_pkg.sv ***
// Package with constants and types for the rotate-right and set-file datapath.
package rrsf_pkg;

  // Register byte offsets on the bus.
  localparam logic [3:0] RRSF_CTRL_OFS = 4'h0;
  localparam logic [3:0] RRSF_BANK_OFS = 4'h4;
  localparam logic [3:0] RRSF_INDEX_OFS = 4'h8;
  localparam logic [3:0] RRSF_STATUS_OFS = 4'hC;

  // Field positions.
  localparam int RRSF_CTRL_EXT_BIT = 0;
  localparam int RRSF_STAT_BUSY_BIT = 0;
  localparam int RRSF_STAT_N_BIT = 1;
  localparam int RRSF_STAT_Z_BIT = 2;
  localparam int RRSF_STAT_RES_LSB = 8;

  // Values after reset.
  localparam logic RRSF_EXT_RST = 1'h0;
  localparam logic [3:0] RRSF_BANK_RST = 4'h0;
  localparam logic [11:0] RRSF_INDEX_RST = 12'h000;
  localparam logic [7:0] RRSF_BYTE_RST = 8'h00;

  // Addressing constants and the set-file all-ones byte.
  localparam logic [7:0] RRSF_LIT_OFS_MAX = 8'h5F;
  localparam logic [7:0] RRSF_ACC_SPLIT = 8'h60;
  localparam logic [3:0] RRSF_ACC_LO_BANK = 4'h0;
  localparam logic [3:0] RRSF_ACC_HI_BANK = 4'hF;
  localparam logic [7:0] RRSF_ALL_ONES = 8'hFF;

  typedef enum logic [1:0] {
    RRSF_OP_ROTATE_RIGHT_NO_CARRY,
    RRSF_OP_SET_FILE_ALL_ONES,
    RRSF_OP_UNUSED_A,
    RRSF_OP_UNUSED_B
  } rrsf_op_e;

  typedef enum logic [2:0] {
    RRSF_IDLE,
    RRSF_Q1,
    RRSF_Q2,
    RRSF_Q3,
    RRSF_Q4
  } rrsf_phase_e;

  // One decoded instruction from the decoder.
  typedef struct packed {
    rrsf_op_e op;
    logic [7:0] faddr;
    logic dest;
    logic acc_sel;
  } rrsf_req_s;

  // Data memory port towards the file registers.
  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic we;
    logic [7:0] wdata;
  } rrsf_mem_s;

  // Classic Wishbone request.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rrsf_wb_s;

endpackage : rrsf_pkg

// *** logic/rrsf_alu.sv ***
// Process stage: no-carry right rotate or all-ones byte with flag results.
`timescale 1ns/1ps
module rrsf_alu
  import rrsf_pkg::*;
(
  // Operation and operand.
  input wire rrsf_op_e op_i,
  input wire logic [7:0] operand_i,
  // Result and flags.
  output logic [7:0] result_o,
  output logic neg_o,
  output logic zero_o,
  output logic flags_upd_o
);

  always_comb begin
    result_o = operand_i;
    flags_upd_o = 1'b0;
    case (op_i)
      RRSF_OP_ROTATE_RIGHT_NO_CARRY: begin
        result_o = {operand_i[0], operand_i[7:1]};
        flags_upd_o = 1'b1;
      end
      RRSF_OP_SET_FILE_ALL_ONES: begin
        result_o = RRSF_ALL_ONES;
      end
      default: begin
        result_o = operand_i;
      end
    endcase
    neg_o = result_o[7];
    zero_o = (result_o == RRSF_BYTE_RST);
  end

endmodule : rrsf_alu

// *** logic/rrsf_core.sv ***
// Four-phase rotate-right and set-file datapath with a Wishbone slave.
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module rrsf_core
  import rrsf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction request from the decoder.
  input wire logic op_valid_i,
  input wire rrsf_req_s op_req_i,
  output logic op_ready_o,
  // Data memory port.
  output rrsf_mem_s mem_o,
  input wire logic [7:0] mem_rdata_i,
  // Accumulator write port.
  output logic [7:0] acc_o,
  output logic acc_we_o,
  // Status flags.
  output logic neg_o,
  output logic zero_o,
  // Wishbone slave.
  input wire rrsf_wb_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  typedef struct packed {
    rrsf_phase_e phase;
    rrsf_req_s req;
    rrsf_mem_s mem;
    logic [7:0] operand;
    logic [7:0] result;
    logic [7:0] acc;
    logic acc_we;
    logic neg;
    logic zero;
    logic ext_en;
    logic [3:0] bank;
    logic [11:0] index;
    logic ack;
    logic [31:0] rdata;
  } rrsf_state_s;

  rrsf_state_s st;
  rrsf_state_s next_st;
  logic [7:0] alu_result;
  logic alu_neg;
  logic alu_zero;
  logic alu_upd;
  logic [11:0] eff_addr;
  logic wb_req;

  // The process stage is purely combinational on the latched operand.
  rrsf_alu u_alu (
    .op_i(st.req.op),
    .operand_i(st.operand),
    .result_o(alu_result),
    .neg_o(alu_neg),
    .zero_o(alu_zero),
    .flags_upd_o(alu_upd)
  );

  // The access bank splits at one boundary: low offsets reach the bottom bank, or the index
  // window when ext_en is set, and the rest reach the top bank, whatever the bank register holds.
  // Operand address formed from the latched request and current bank state.
  always_comb begin
    if (st.req.acc_sel) begin
      eff_addr = {st.bank, st.req.faddr};
    end else if (st.ext_en && (st.req.faddr <= RRSF_LIT_OFS_MAX)) begin
      eff_addr = st.index + {4'h0, st.req.faddr};
    end else if (st.req.faddr < RRSF_ACC_SPLIT) begin
      eff_addr = {RRSF_ACC_LO_BANK, st.req.faddr};
    end else begin
      eff_addr = {RRSF_ACC_HI_BANK, st.req.faddr};
    end
  end

  // A request is taken only while no ack is out, so the cycle that carries
  // the ack is never taken a second time while the master releases it.
  assign wb_req = wb_i.cyc && wb_i.stb && !st.ack;

  always_comb begin
    next_st = st;
    // Strobes default low so that each stands for one cycle only.
    next_st.mem.rd = 1'b0;
    next_st.mem.we = 1'b0;
    next_st.acc_we = 1'b0;
    next_st.ack = wb_req;
    next_st.rdata = 32'h0000_0000;

    // Register bus: single-cycle registered ack, unmapped reads give zero.
    if (wb_req && wb_i.we) begin
      case (wb_i.adr)
        RRSF_CTRL_OFS: begin
          if (wb_i.sel[0]) begin
            next_st.ext_en = wb_i.dat[RRSF_CTRL_EXT_BIT];
          end
        end
        RRSF_BANK_OFS: begin
          if (wb_i.sel[0]) begin
            next_st.bank = wb_i.dat[3:0];
          end
        end
        RRSF_INDEX_OFS: begin
          if (wb_i.sel[0]) begin
            next_st.index[7:0] = wb_i.dat[7:0];
          end
          if (wb_i.sel[1]) begin
            next_st.index[11:8] = wb_i.dat[11:8];
          end
        end
        default: begin
          next_st.ack = wb_req;
        end
      endcase
    end else if (wb_req) begin
      case (wb_i.adr)
        RRSF_CTRL_OFS: begin
          next_st.rdata[RRSF_CTRL_EXT_BIT] = st.ext_en;
        end
        RRSF_BANK_OFS: begin
          next_st.rdata[3:0] = st.bank;
        end
        RRSF_INDEX_OFS: begin
          next_st.rdata[11:0] = st.index;
        end
        RRSF_STATUS_OFS: begin
          next_st.rdata[RRSF_STAT_BUSY_BIT] = (st.phase != RRSF_IDLE);
          next_st.rdata[RRSF_STAT_N_BIT] = st.neg;
          next_st.rdata[RRSF_STAT_Z_BIT] = st.zero;
          next_st.rdata[RRSF_STAT_RES_LSB +: 8] = st.result;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Instruction sequence, one phase per clock.
    case (st.phase)
      RRSF_IDLE: begin
        if (op_valid_i) begin
          next_st.req = op_req_i;
          next_st.phase = RRSF_Q1;
        end
      end
      RRSF_Q1: begin
        next_st.mem.addr = eff_addr;
        next_st.mem.rd = 1'b1;
        next_st.phase = RRSF_Q2;
      end
      // Read data is sampled in the cycle in which the read strobe stands,
      // so the data memory must answer combinationally within it.
      RRSF_Q2: begin
        next_st.operand = mem_rdata_i;
        next_st.phase = RRSF_Q3;
      end
      RRSF_Q3: begin
        next_st.result = alu_result;
        if (alu_upd) begin
          next_st.neg = alu_neg;
          next_st.zero = alu_zero;
        end
        // Set-file has no destination choice: it always targets the file.
        if (st.req.op == RRSF_OP_SET_FILE_ALL_ONES) begin
          next_st.mem.we = 1'b1;
          next_st.mem.wdata = alu_result;
        end else if (!st.req.dest) begin
          next_st.acc = alu_result;
          next_st.acc_we = 1'b1;
        end else begin
          next_st.mem.we = 1'b1;
          next_st.mem.wdata = alu_result;
        end
        next_st.phase = RRSF_Q4;
      end
      // Q4 lets the write pulse stand before the next decode is allowed.
      RRSF_Q4: begin
        next_st.phase = RRSF_IDLE;
      end
      default: begin
        next_st.phase = RRSF_IDLE;
      end
    endcase
  end

  // Plain synchronous reset of every state bit.
  // The whole struct is cleared first so that no field is left unknown,
  // then the named fields take their own reset values.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.phase <= RRSF_IDLE;
      st.ext_en <= RRSF_EXT_RST;
      st.bank <= RRSF_BANK_RST;
      st.index <= RRSF_INDEX_RST;
      st.acc <= RRSF_BYTE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register; only the ready
  // handshake is decoded from the phase.
  assign op_ready_o = (st.phase == RRSF_IDLE);
  assign mem_o = st.mem;
  assign acc_o = st.acc;
  assign acc_we_o = st.acc_we;
  assign neg_o = st.neg;
  assign zero_o = st.zero;
  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;

endmodule : rrsf_core

// *** sim/rrsf_core_properties.sv ***
// Checker with phase timing and result properties of the datapath.
`timescale 1ns/1ps
module rrsf_core_props
  import rrsf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction and memory side.
  input wire logic op_valid_i,
  input wire rrsf_req_s op_req_i,
  input wire logic op_ready_o,
  input wire rrsf_mem_s mem_o,
  input wire logic [7:0] mem_rdata_i,
  // Accumulator and flags.
  input wire logic [7:0] acc_o,
  input wire logic acc_we_o,
  input wire logic neg_o,
  input wire logic zero_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic st;
  logic rot;
  logic sf;
  logic [7:0] exp_q;
  assign st = op_valid_i && op_ready_o;
  assign sf = st && op_req_i.op == RRSF_OP_SET_FILE_ALL_ONES;
  // The operand is only valid in the read phase, so keep its rotation.
  always_ff @(posedge clk_i) begin
    if (st) rot <= op_req_i.op == RRSF_OP_ROTATE_RIGHT_NO_CARRY;
    if (mem_o.rd) exp_q <= {mem_rdata_i[0], mem_rdata_i[7:1]};
  end
  rd_phase_a: assert property (st |-> ##2 mem_o.rd)
    else $error("read not in phase two");
  busy_span_a: assert property (st |=> !op_ready_o [*4] ##1 op_ready_o)
    else $error("cycle length wrong");
  rot_file_a: assert property (mem_o.we && rot |-> mem_o.wdata == exp_q)
    else $error("file rotate wrong");
  rot_acc_a: assert property (acc_we_o && rot |-> acc_o == exp_q
    && neg_o == acc_o[7] && zero_o == (acc_o == 8'h00))
    else $error("acc rotate");
  dest_sel_a: assert property (st && !op_req_i.dest
    && op_req_i.op == RRSF_OP_ROTATE_RIGHT_NO_CARRY
    |-> ##4 acc_we_o && !mem_o.we) else $error("destination wrong");
  dest_file_a: assert property (st && op_req_i.dest
    && op_req_i.op == RRSF_OP_ROTATE_RIGHT_NO_CARRY
    |-> ##4 mem_o.we && !acc_we_o) else $error("file destination wrong");
  set_file_a: assert property (sf |-> ##4 mem_o.we && !acc_we_o
    && mem_o.wdata == RRSF_ALL_ONES) else $error("set file wrong");
  set_flags_a: assert property (sf |=> $stable({neg_o, zero_o}) [*5])
    else $error("set file moved flags");
  bank_addr_a: assert property (st && op_req_i.acc_sel
    |-> ##2 mem_o.addr[7:0] == $past(op_req_i.faddr, 2)) else $error("bank");
  access_hi_a: assert property (st && !op_req_i.acc_sel
    && op_req_i.faddr > RRSF_LIT_OFS_MAX |-> ##2 mem_o.addr ==
    {RRSF_ACC_HI_BANK, $past(op_req_i.faddr, 2)}) else $error("access bank");
  cover property (sf);
  cover property (acc_we_o && rot);
  cover property (st && !op_req_i.acc_sel && op_req_i.faddr <= 8'h5F);
endmodule : rrsf_core_props
bind rrsf_core rrsf_core_props u_props (.clk_i, .rst_i, .op_valid_i,
  .op_req_i, .op_ready_o, .mem_o, .mem_rdata_i, .acc_o, .acc_we_o, .neg_o,
  .zero_o);

// *** sim/testbench.sv ***
// Self-checking bench of the rotate-right and set-file datapath.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench
  import rrsf_pkg::*;
;
  logic clk_i = 0, rst_i = 1, op_valid_i = 0, op_ready_o, acc_we_o;
  logic neg_o, zero_o, wb_ack_o;
  logic [7:0] mem_rdata_i = 8'h00, acc_o;
  logic [31:0] wb_dat_o, rd;
  rrsf_req_s op_req_i = '0;
  rrsf_mem_s mem_o;
  rrsf_wb_s wb_i = '0;
  int num_errors = 0, total_checks = 0, cyc_n = 0;
  // Row: op, address, dest and access bits, operand, result, memory address.
  logic [39:0] rows [5] = '{{2'h0, 8'h12, 2'h3, 8'hD7, 8'hEB, 12'h312},
    {2'h0, 8'h20, 2'h0, 8'h01, 8'h80, 12'h020},
    {2'h0, 8'h80, 2'h2, 8'h00, 8'h00, 12'hF80},
    {2'h1, 8'h5A, 2'h1, 8'h5A, 8'hFF, 12'h35A},
    {2'h2, 8'h30, 2'h2, 8'h96, 8'h96, 12'h030}};
  rrsf_core u_dut (.clk_i, .rst_i, .op_valid_i, .op_req_i, .op_ready_o,
    .mem_o, .mem_rdata_i, .acc_o, .acc_we_o, .neg_o, .zero_o, .wb_i,
    .wb_dat_o, .wb_ack_o);
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // A hang anywhere ends the run as a failure.
  always @(posedge clk_i) begin
    if (++cyc_n == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, w, ad, 4'hF, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask : wb
  task automatic run(input logic [39:0] row);
    rrsf_req_s q;
    logic [7:0] v, r;
    logic [11:0] a;
    logic aw;
    logic rt;
    logic [1:0] f;
    {q, v, r, a} = row;
    rt = q.op == RRSF_OP_ROTATE_RIGHT_NO_CARRY;
    aw = q.op != RRSF_OP_SET_FILE_ALL_ONES && !q.dest;
    @(posedge clk_i);
    f = {neg_o, zero_o};
    op_valid_i <= 1'b1;
    op_req_i <= q;
    mem_rdata_i <= v;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    do @(posedge clk_i); while (acc_we_o !== 1'b1 && mem_o.we !== 1'b1);
    `CHK(acc_we_o, aw)
    `CHK(aw ? acc_o : mem_o.wdata, r)
    `CHK(mem_o.addr, a)
    `CHK({neg_o, zero_o}, rt ? {r[7], r == 8'h00} : f)
  endtask : run
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({op_ready_o, acc_we_o, mem_o.we}, 3'h4)
    wb(1'b1, RRSF_BANK_OFS, 32'h3);
    wb(1'b0, RRSF_BANK_OFS, 32'h0);
    `CHK(rd, 32'h3)
    wb(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    foreach (rows[i]) run(rows[i]);
    wb(1'b0, RRSF_STATUS_OFS, 32'h0);
    `CHK(rd, 32'h0000_9604)
    // Literal offset only applies up to the boundary, never on bank access.
    wb(1'b1, RRSF_INDEX_OFS, 32'h100);
    wb(1'b1, RRSF_CTRL_OFS, 32'h1);
    wb(1'b0, RRSF_CTRL_OFS, 32'h0);
    `CHK(rd, 32'h1)
    run({2'h0, 8'h5F, 2'h0, 8'hAA, 8'h55, 12'h15F});
    run({2'h0, 8'h60, 2'h2, 8'h02, 8'h01, 12'hF60});
    wb(1'b1, RRSF_BANK_OFS, 32'h7);
    run({2'h1, 8'h5F, 2'h1, 8'h00, 8'hFF, 12'h75F});
    // Reset in mid-operation abandons it and restores every default.
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({op_ready_o, acc_we_o, mem_o.we, acc_o}, 11'h400)
    wb(1'b0, RRSF_BANK_OFS, 32'h0);
    `CHK(rd, 32'h0)
    end_of_test();
  end
endmodule : testbench
